// ==== rtl/trs_pkg.sv ====
// Purpose: shared constants for the rollover timer with sleep counting and capture/compare time base
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   all offsets are byte addresses
package trs_pkg;

  // register byte offsets
  localparam logic [7:0] TRS_OFS_TIMER_CTRL  = 8'h00; // timer_control_register
  localparam logic [7:0] TRS_OFS_CNT_LO      = 8'h04; // counter_low_byte
  localparam logic [7:0] TRS_OFS_CNT_HI      = 8'h08; // counter_high_byte
  localparam logic [7:0] TRS_OFS_CC_LO       = 8'h0C; // capcomp_low_byte
  localparam logic [7:0] TRS_OFS_CC_HI       = 8'h10; // capcomp_high_byte
  localparam logic [7:0] TRS_OFS_CC_CTRL     = 8'h14; // capture/compare mode control
  localparam logic [7:0] TRS_OFS_GLOBAL_IRQ  = 8'h18; // global_interrupt_control
  localparam logic [7:0] TRS_OFS_PERIPH_IE   = 8'h1C; // peripheral_interrupt_enable_one
  localparam logic [7:0] TRS_OFS_PERIPH_IF   = 8'h20; // peripheral_interrupt_flag_one

  // field positions
  localparam int TRS_BIT_RUN       = 0; // timer_run_enable
  localparam int TRS_BIT_CLK_SEL   = 1; // clock_source_select: 1 = external pin
  localparam int TRS_BIT_SYNC_BYP  = 2; // sync_bypass: 1 = asynchronous counter
  localparam int TRS_BIT_OSC_EN    = 3; // secondary_osc_enable
  localparam int TRS_BIT_CAPTURE   = 0; // capture mode
  localparam int TRS_BIT_COMPARE   = 1; // compare mode
  localparam int TRS_BIT_AUTO_TRIG = 2; // compare match is an auto-conversion trigger
  localparam int TRS_BIT_GLOBAL_IE = 7; // global_irq_enable
  localparam int TRS_BIT_PERIPH_IE = 6; // peripheral_irq_enable
  localparam int TRS_BIT_TMR_OVF   = 0; // timer overflow enable / flag
  localparam int TRS_BIT_CC_EVT    = 2; // capture/compare enable / flag

  // reset values
  localparam logic [7:0]  TRS_RST_BYTE    = 8'h00;
  localparam logic [15:0] TRS_RST_WORD    = 16'h0000;
  localparam logic [15:0] TRS_CNT_ALL_ONE = 16'hFFFF;

  // AXI response codes
  localparam logic [1:0] TRS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TRS_RESP_SLVERR = 2'h2;

endpackage : trs_pkg

// ==== rtl/trs_sync3.sv ====
// Purpose: three-stage synchroniser for a pin, with a rising-edge pulse
// Assumes: pin is asynchronous to clk_in
// Notes:   a change counts once stages two and three agree; stage one feeds only stage two
`timescale 1ns/10ps
module trs_sync3 (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // pin side
  input  wire logic pin_in,
  // synchronised side
  output logic      level_out,
  output logic      rise_out
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;

  // three flip-flop chain
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end else begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // accepted level moves only when stages two and three agree
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      level_q <= 1'b0;
    end else if (stage2_q == stage3_q) begin
      level_q <= stage3_q;
    end
  end

  // level and single-cycle rise pulse, idle low after reset so no false edge
  assign level_out = level_q;
  assign rise_out  = (stage2_q == stage3_q) & stage3_q & ~level_q;

endmodule : trs_sync3

// ==== rtl/trs_timer.sv ====
// Purpose: 16-bit rollover timer with overflow flag, sleep counting, wake-up and capture/compare time base
// Assumes: AXI4-Lite slave at 100 MHz on clk_in; external clock and capture event arrive on pins
// Notes:   counter priority is software write, then auto-trigger clear, then increment
// Overview of operation
// R1: counter counts up in sixteen bits and wraps from all ones to zero.
// R2: every wrap sets the timer overflow flag in the peripheral flag register.
// R3: overflow interrupt request needs run, overflow enable, peripheral enable and global enable.
// R4: software clears the overflow flag; hardware keeps it set until then.
// R5: software should zero counter and flag before enabling the interrupt.
// R6: in sleep only the asynchronous external-clock counter advances; otherwise it holds.
// R7: software sets run, enables, sync bypass, source and oscillator to allow wake.
// R8: overflow in sleep wakes the device; with global enable it also interrupts.
// R9: secondary oscillator keeps running in sleep whatever the sync bypass bit.
// R10: capture and compare use the 16-bit counter as their time base.
// R11: a capture event copies the counter into the capture/compare pair.
// R12: in compare mode a match raises an event, optionally an auto-conversion trigger.
// R13: an auto-conversion trigger clears the counter to zero.
// R14: the trigger clear never sets the overflow flag; compare flag may still set.
// R15: with auto trigger the compare pair acts as the counter period.
// R16: software should use synchronous instruction-clock counting with auto triggers.
// R17: a counter byte write in the trigger cycle wins over the clear.
// R18: counter advances once per selected tick only while run enable is set.
// R19: overflow flag sets in the wrap cycle regardless of interrupt enables.
`timescale 1ns/10ps
module trs_timer
  import trs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // device pins and state
  input  wire logic        ext_clk_in,
  input  wire logic        capture_evt_in,
  input  wire logic        sleep_in,
  // events to the system
  output logic             irq_out,
  output logic             wake_out,
  output logic             compare_evt_out,
  output logic             auto_trig_out,
  output logic             osc_run_out
);

  // register state
  logic [7:0]  tctrl_q;
  logic [7:0]  ccctrl_q;
  logic [7:0]  gie_reg_q;
  logic [7:0]  pie_reg_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] cc_q;
  logic        ovf_flag_q;
  logic        cc_flag_q;
  // bus state
  logic        awready_q;
  logic        wready_q;
  logic        arready_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_d;
  logic        rd_hit;
  // outputs
  logic        irq_q;
  logic        wake_q;
  logic        cmp_evt_q;
  logic        auto_q;
  logic        osc_q;
  // internal
  logic        ext_tick;
  logic        cap_rise;
  logic        wr_do;
  logic        wr_lo;
  logic        wr_lo_cnt;
  logic        wr_hi_cnt;
  logic        wr_cnt;
  logic        tick;
  logic        inc;
  logic        wrap;
  logic        match;
  logic        trig;
  logic        async_mode;

  // pin synchronisers
  trs_sync3 u_ext_sync (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .pin_in    (ext_clk_in),
    .level_out (),
    .rise_out  (ext_tick)
  );

  trs_sync3 u_cap_sync (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .pin_in    (capture_evt_in),
    .level_out (),
    .rise_out  (cap_rise)
  );

  // bus write takes place once address and data are both held
  assign wr_do     = ~awready_q & ~wready_q & ~bvalid_q;
  assign wr_lo     = wr_do & w_strb_q[0];
  assign wr_lo_cnt = wr_lo & (aw_addr_q == TRS_OFS_CNT_LO);
  assign wr_hi_cnt = wr_lo & (aw_addr_q == TRS_OFS_CNT_HI);
  assign wr_cnt    = wr_lo_cnt | wr_hi_cnt;

  // counting conditions
  assign async_mode = tctrl_q[TRS_BIT_CLK_SEL] & tctrl_q[TRS_BIT_SYNC_BYP];
  assign tick  = tctrl_q[TRS_BIT_CLK_SEL] ? ext_tick : 1'b1;
  assign inc   = tctrl_q[TRS_BIT_RUN] & tick & (~sleep_in | async_mode); // see R18 see R6
  assign wrap  = inc & (cnt_q == TRS_CNT_ALL_ONE);                      // see R1
  assign match = ccctrl_q[TRS_BIT_COMPARE] & (cc_q == cnt_q);           // see R12 see R10
  assign trig  = match & ccctrl_q[TRS_BIT_AUTO_TRIG];                   // see R15

  // counter next value: write beats clear beats increment
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt) begin                                                   // see R17
      if (wr_lo_cnt) cnt_d[7:0] = w_data_q[7:0];
      if (wr_hi_cnt) cnt_d[15:8] = w_data_q[7:0];
    end else if (trig) begin
      cnt_d = TRS_RST_WORD;                                             // see R13
    end else if (inc) begin
      cnt_d = cnt_q + 16'h0001;                                         // see R1
    end
  end

  // counter register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) cnt_q <= TRS_RST_WORD;
    else          cnt_q <= cnt_d;
  end

  // overflow flag: wrap sets, software write of zero clears, set wins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ovf_flag_q <= 1'b0;
    end else if (wrap & ~wr_cnt & ~trig) begin
      ovf_flag_q <= 1'b1;                                               // see R2 see R19 see R14
    end else if (wr_lo & (aw_addr_q == TRS_OFS_PERIPH_IF)) begin
      ovf_flag_q <= w_data_q[TRS_BIT_TMR_OVF];                          // see R4
    end
  end

  // capture/compare flag: capture or match sets, software clears
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cc_flag_q <= 1'b0;
    end else if (match | (cap_rise & ccctrl_q[TRS_BIT_CAPTURE])) begin
      cc_flag_q <= 1'b1;
    end else if (wr_lo & (aw_addr_q == TRS_OFS_PERIPH_IF)) begin
      cc_flag_q <= w_data_q[TRS_BIT_CC_EVT];
    end
  end

  // capture/compare pair: capture event copies counter, else software write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cc_q <= TRS_RST_WORD;
    end else if (cap_rise & ccctrl_q[TRS_BIT_CAPTURE]) begin
      cc_q <= cnt_q;                                                    // see R11 see R10
    end else if (wr_lo & (aw_addr_q == TRS_OFS_CC_LO)) begin
      cc_q[7:0] <= w_data_q[7:0];
    end else if (wr_lo & (aw_addr_q == TRS_OFS_CC_HI)) begin
      cc_q[15:8] <= w_data_q[7:0];
    end
  end

  // control registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tctrl_q   <= TRS_RST_BYTE;
      ccctrl_q  <= TRS_RST_BYTE;
      gie_reg_q <= TRS_RST_BYTE;
      pie_reg_q <= TRS_RST_BYTE;
    end else if (wr_lo) begin
      if (aw_addr_q == TRS_OFS_TIMER_CTRL) tctrl_q <= {4'h0, w_data_q[3:0]};
      if (aw_addr_q == TRS_OFS_CC_CTRL)    ccctrl_q <= {5'h00, w_data_q[2:0]};
      if (aw_addr_q == TRS_OFS_GLOBAL_IRQ) gie_reg_q <= {w_data_q[7:6], 6'h00};
      if (aw_addr_q == TRS_OFS_PERIPH_IE)  pie_reg_q <= {5'h00, w_data_q[2], 1'b0, w_data_q[0]};
    end
  end

  // interrupt, wake and event outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_q     <= 1'b0;
      wake_q    <= 1'b0;
      cmp_evt_q <= 1'b0;
      auto_q    <= 1'b0;
      osc_q     <= 1'b0;
    end else begin
      irq_q     <= ((ovf_flag_q & pie_reg_q[TRS_BIT_TMR_OVF] & tctrl_q[TRS_BIT_RUN]) |
                    (cc_flag_q & pie_reg_q[TRS_BIT_CC_EVT])) &
                   gie_reg_q[TRS_BIT_PERIPH_IE] & gie_reg_q[TRS_BIT_GLOBAL_IE];   // see R3 see R8
      wake_q    <= sleep_in & ovf_flag_q & pie_reg_q[TRS_BIT_TMR_OVF] &
                   tctrl_q[TRS_BIT_RUN] & gie_reg_q[TRS_BIT_PERIPH_IE];           // see R8
      cmp_evt_q <= match;
      auto_q    <= trig;
      osc_q     <= tctrl_q[TRS_BIT_OSC_EN];                                       // see R9
    end
  end

  // write channel: hold address and data until both are present
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= TRS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in & awready_q) begin
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in & wready_q) begin
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (aw_addr_q > TRS_OFS_PERIPH_IF || aw_addr_q[1:0] != 2'h0) ?
                    TRS_RESP_SLVERR : TRS_RESP_OKAY;
      end
      if (bvalid_q & s_axi_bready_in) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr_in)
      TRS_OFS_TIMER_CTRL: rdata_d[7:0] = tctrl_q;
      TRS_OFS_CNT_LO:     rdata_d[7:0] = cnt_q[7:0];
      TRS_OFS_CNT_HI:     rdata_d[7:0] = cnt_q[15:8];
      TRS_OFS_CC_LO:      rdata_d[7:0] = cc_q[7:0];
      TRS_OFS_CC_HI:      rdata_d[7:0] = cc_q[15:8];
      TRS_OFS_CC_CTRL:    rdata_d[7:0] = ccctrl_q;
      TRS_OFS_GLOBAL_IRQ: rdata_d[7:0] = gie_reg_q;
      TRS_OFS_PERIPH_IE:  rdata_d[7:0] = pie_reg_q;
      TRS_OFS_PERIPH_IF:  rdata_d[7:0] = {5'h00, cc_flag_q, 1'b0, ovf_flag_q};
      default:            rd_hit = 1'b0;
    endcase
  end

  // read channel: one cycle from address to data
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= TRS_RESP_OKAY;
    end else if (s_axi_arvalid_in & arready_q) begin
      rvalid_q  <= 1'b1;
      arready_q <= 1'b0;
      rdata_q   <= rdata_d;
      rresp_q   <= rd_hit ? TRS_RESP_OKAY : TRS_RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready_in) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // port drive
  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out  = wready_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;
  assign irq_out           = irq_q;
  assign wake_out          = wake_q;
  assign compare_evt_out   = cmp_evt_q;
  assign auto_trig_out     = auto_q;
  assign osc_run_out       = osc_q;

  // checks on counter, flags and outputs
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_count_step_up: assert property (inc & ~wr_cnt & ~trig & cnt_q != TRS_CNT_ALL_ONE |=> // see R1 see R18
    cnt_q == $past(cnt_q) + 16'h0001) else $error("counter did not step by one");
  a_wrap_sets_flag: assert property (wrap & ~wr_cnt & ~trig |=> ovf_flag_q && cnt_q == 16'h0000) // see R2 see R19
    else $error("wrap did not set flag in the same cycle");
  a_hold_when_off: assert property (~tctrl_q[TRS_BIT_RUN] & ~wr_cnt & ~trig |=> $stable(cnt_q)) // see R18
    else $error("counter moved while stopped");
  a_sleep_hold: assert property (sleep_in & ~async_mode & ~wr_cnt & ~trig |=> $stable(cnt_q)) // see R6
    else $error("counter moved in sleep outside async mode");
  a_flag_sticky: assert property (ovf_flag_q & ~(wr_lo & aw_addr_q == TRS_OFS_PERIPH_IF) |=> ovf_flag_q) // see R4
    else $error("overflow flag dropped without software clear");
  a_irq_gating: assert property (irq_out & ~cc_flag_q & ~$past(cc_flag_q) |-> // see R3
    $past(tctrl_q[TRS_BIT_RUN] & pie_reg_q[TRS_BIT_TMR_OVF] & gie_reg_q[7] & gie_reg_q[6]))
    else $error("interrupt raised without all enables");
  a_trig_clears: assert property (trig & ~wr_cnt |=> cnt_q == 16'h0000 && auto_trig_out) // see R13
    else $error("auto trigger did not clear counter");
  a_trig_no_flag: assert property (trig & ~wr_cnt & ~ovf_flag_q & ~wr_lo |=> ~ovf_flag_q) // see R14
    else $error("trigger clear set overflow flag");
  a_write_wins: assert property (trig & wr_lo_cnt |=> cnt_q[7:0] == $past(w_data_q[7:0])) // see R17
    else $error("trigger clear beat a counter write");
  a_capture_copy: assert property (cap_rise & ccctrl_q[TRS_BIT_CAPTURE] |=> cc_q == $past(cnt_q)) // see R11
    else $error("capture did not copy counter");
  a_osc_follows: assert property (##1 osc_run_out == $past(tctrl_q[TRS_BIT_OSC_EN])) // see R9
    else $error("oscillator run did not follow enable");

endmodule : trs_timer

// ==== bench/trs_pin_model.sv ====
// Purpose: pin-side model of the external counter clock and the capture event source
// Assumes: requests arrive as one-cycle go pulses on clk_in
// Notes:   the external clock stands low between bursts
`timescale 1ns/10ps
module trs_pin_model (
  // clock
  input  wire logic       clk_in,
  // requests from the bench
  input  wire logic       ext_go_in,
  input  wire logic [3:0] ext_n_in,
  input  wire logic       cap_go_in,
  // pins
  output logic            ext_clk_out,
  output logic            capture_evt_out
);
  // bursts of slow pulses, each phase four clocks so the synchroniser sees it
  initial begin
    ext_clk_out     = 1'b0;
    capture_evt_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (ext_go_in) begin
        repeat (ext_n_in) begin
          ext_clk_out <= 1'b1;
          repeat (4) @(posedge clk_in);
          ext_clk_out <= 1'b0;
          repeat (4) @(posedge clk_in);
        end
      end else if (cap_go_in) begin
        capture_evt_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        capture_evt_out <= 1'b0;
      end
    end
  end
endmodule : trs_pin_model

// ==== bench/tb_trs_timer.sv ====
// Purpose: self-checking bench for the rollover timer
// Assumes: bready and rready held high, one transfer at a time
// Notes:   event outputs are sampled on the falling edge, bus responses on the rising edge
`timescale 1ns/10ps
module tb_trs_timer
  import trs_pkg::*;
;
  logic        clk_in, nrst_in, awvalid, wvalid, arvalid, awready, wready, arready;
  logic        bvalid, rvalid, ext_clk, cap_evt, sleep, irq, wake, cmp_evt, trig, osc_run;
  logic        ext_go, cap_go;
  logic [3:0]  ext_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  int          bad_count, checks, n;

  // clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  trs_timer i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
    .ext_clk_in(ext_clk), .capture_evt_in(cap_evt), .sleep_in(sleep),
    .irq_out(irq), .wake_out(wake), .compare_evt_out(cmp_evt), .auto_trig_out(trig), .osc_run_out(osc_run));

  trs_pin_model i_pins (
    .clk_in(clk_in), .ext_go_in(ext_go), .ext_n_in(ext_n), .cap_go_in(cap_go),
    .ext_clk_out(ext_clk), .capture_evt_out(cap_evt));

  task automatic final_report;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    // wait for the response; only the watchdog ends a hang
    do begin
      @(posedge clk_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
  endtask : wr

  task automatic rdreg(input logic [7:0] a);
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    // data taken at the edge where rvalid is sampled high
    do begin
      @(posedge clk_in);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd  = rdata;
    rsp = rresp;
  endtask : rdreg

  task automatic pulse(input logic [3:0] k);
    @(posedge clk_in);
    ext_n  <= k;
    ext_go <= 1'b1;
    @(posedge clk_in);
    ext_go <= 1'b0;
    repeat (k * 8 + 8) @(posedge clk_in);
    @(negedge clk_in);
  endtask : pulse

  // watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    final_report();
  end

  // test sequence
  initial begin
    {nrst_in, awvalid, wvalid, arvalid, ext_go, cap_go, sleep} = '0;
    {awaddr, araddr, wdata, ext_n} = '0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    // reset values, unmapped place
    for (n = 0; n < 9; n++) begin
      rdreg(8'(n * 4));
      check(rd, {24'h0, TRS_RST_BYTE});
    end
    rdreg(8'h24);
    check(rsp, TRS_RESP_SLVERR);
    wr(8'h24, 8'hFF);
    check(rsp, TRS_RESP_SLVERR);
    // hold while stopped, then wrap
    wr(TRS_OFS_CNT_HI, 8'hFF);
    wr(TRS_OFS_CNT_LO, 8'hFF);
    repeat (5) @(posedge clk_in);
    rdreg(TRS_OFS_CNT_LO);
    check(rd, 32'hFF);
    wr(TRS_OFS_PERIPH_IE, 8'h01);
    wr(TRS_OFS_GLOBAL_IRQ, 8'h40);
    wr(TRS_OFS_TIMER_CTRL, 8'h01);
    repeat (4) @(negedge clk_in);
    check(irq, 0);
    rdreg(TRS_OFS_PERIPH_IF);
    check(rd, 32'h01);
    rdreg(TRS_OFS_CNT_HI);
    check(rd, 32'h00);
    wr(TRS_OFS_GLOBAL_IRQ, 8'hC0);
    repeat (2) @(negedge clk_in);
    check(irq, 1);
    wr(TRS_OFS_TIMER_CTRL, 8'h00);
    repeat (2) @(negedge clk_in);
    check(irq, 0);
    rdreg(TRS_OFS_PERIPH_IF);
    check(rd, 32'h01);
    wr(TRS_OFS_PERIPH_IF, 8'h00);
    wr(TRS_OFS_GLOBAL_IRQ, 8'h40);
    rdreg(TRS_OFS_PERIPH_IF);
    check(rd, 32'h00);
    // external ticks carry across the byte boundary
    wr(TRS_OFS_CNT_LO, 8'hFF);
    wr(TRS_OFS_CNT_HI, 8'h00);
    wr(TRS_OFS_TIMER_CTRL, 8'h03);
    pulse(4'd1);
    rdreg(TRS_OFS_CNT_HI);
    check(rd, 32'h01);
    pulse(4'd2);
    rdreg(TRS_OFS_CNT_LO);
    check(rd, 32'h02);
    // sleep: only the asynchronous counter moves
    sleep <= 1'b1;
    wr(TRS_OFS_TIMER_CTRL, 8'h01);
    repeat (10) @(posedge clk_in);
    rdreg(TRS_OFS_CNT_LO);
    check(rd, 32'h02);
    wr(TRS_OFS_TIMER_CTRL, 8'h07);
    pulse(4'd3);
    rdreg(TRS_OFS_CNT_LO);
    check(rd, 32'h05);
    wr(TRS_OFS_TIMER_CTRL, 8'h03);
    pulse(4'd1);
    rdreg(TRS_OFS_CNT_LO);
    check(rd, 32'h05);
    // wake on overflow in sleep
    wr(TRS_OFS_CNT_LO, 8'hFF);
    wr(TRS_OFS_CNT_HI, 8'hFF);
    wr(TRS_OFS_TIMER_CTRL, 8'h0F);
    pulse(4'd1);
    check(wake, 1);
    check(irq, 0);
    check(osc_run, 1);
    wr(TRS_OFS_TIMER_CTRL, 8'h0B);
    @(negedge clk_in);
    check(osc_run, 1);
    // capture copies the counter
    wr(TRS_OFS_TIMER_CTRL, 8'h00);
    sleep <= 1'b0;
    wr(TRS_OFS_PERIPH_IF, 8'h00);
    wr(TRS_OFS_CNT_LO, 8'h55);
    wr(TRS_OFS_CC_CTRL, 8'h01);
    @(posedge clk_in);
    cap_go <= 1'b1;
    @(posedge clk_in);
    cap_go <= 1'b0;
    repeat (12) @(posedge clk_in);
    rdreg(TRS_OFS_CC_LO);
    check(rd, 32'h55);
    rdreg(TRS_OFS_CC_HI);
    check(rd, 32'h00);
    rdreg(TRS_OFS_PERIPH_IF);
    check(rd, 32'h04);
    // write beats a coincident trigger clear
    wr(TRS_OFS_PERIPH_IF, 8'h00);
    wr(TRS_OFS_CNT_LO, 8'h00);
    wr(TRS_OFS_CC_LO, 8'h00);
    wr(TRS_OFS_CC_CTRL, 8'h06);
    repeat (2) @(negedge clk_in);
    check(trig, 1);
    wr(TRS_OFS_CNT_LO, 8'h09);
    rdreg(TRS_OFS_CNT_LO);
    check(rd, 32'h09);
    // compare pair acts as the period
    wr(TRS_OFS_CC_LO, 8'h05);
    wr(TRS_OFS_CNT_LO, 8'h00);
    wr(TRS_OFS_TIMER_CTRL, 8'h01);
    for (n = 0; n < 40 && trig !== 1'b1; n++) @(negedge clk_in);
    check(trig, 1);
    check(cmp_evt, 1);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (trig !== 1'b1 && n < 40);
    check(n, 6);
    rdreg(TRS_OFS_CNT_HI);
    check(rd, 32'h00);
    rdreg(TRS_OFS_PERIPH_IF);
    check({31'h0, rd[0]}, 32'h0);
    final_report();
  end
endmodule : tb_trs_timer
